/* rtl/iots_pkg.sv */
/*
 * Constants for the internal oscillator tuning and start-up status block.
 * Assumes a single 50 MHz system clock and a byte-wide register port.
 */
package iots_pkg;
    // Register offsets on the byte port
    localparam logic [7:0] IOTS_OSC_CTRL_OFFSET = 8'h8F;
    localparam logic [7:0] IOTS_TRIM_OFFSET = 8'h90;
    // Field layout
    localparam int IOTS_TRIM_WIDTH = 5;
    localparam int IOTS_STATUS_BIT = 3;
    // Values after reset
    localparam logic [4:0] IOTS_TRIM_RESET = 5'h00;
    localparam logic [7:0] IOTS_RDATA_RESET = 8'h00;
    // Slew counter reload value; single trim steps of the fast oscillator come every 16 cycles
    localparam logic [3:0] IOTS_SLEW_CYCLES = 4'hF;
    // Slow timebase divider reload value; one tick every 16 cycles
    localparam logic [3:0] IOTS_SLOW_DIV = 4'hF;
endpackage : iots_pkg

/* rtl/iots_slow_timebase.sv */
/*
 * Slow internal oscillator timebase: a fixed divider giving one tick per period.
 * Assumes nothing of the trim logic; it has no input from it by design.
 */
`timescale 1ns/1ps
module iots_slow_timebase
    import iots_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Timebase output
    output logic slow_tick
);
    typedef struct packed {
        logic [3:0] div_reg;
        logic tick_reg;
    } iots_tb_state_t;

    iots_tb_state_t st_reg;
    iots_tb_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Fixed divider, independent of any trim value
    always_comb
    begin
        st_next = st_reg;
        st_next.tick_reg = 1'b0;
        if (st_reg.div_reg == 4'h0)
        begin
            st_next.div_reg = IOTS_SLOW_DIV;
            st_next.tick_reg = 1'b1;
        end
        else
        begin
            st_next.div_reg = st_reg.div_reg - 4'h1;
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign slow_tick = st_reg.tick_reg;
endmodule : iots_slow_timebase

/* rtl/iots_top.sv */
/*
 * Internal oscillator tuning register, fast oscillator trim slew and start-up
 * clock status, with a slow timebase that the trim never touches.
 * Assumes a byte register port with one-cycle strobes and read data one
 * cycle later, and a clock switch that reports when the internal source runs.
 */
// Function
// - Trim register keeps a signed five-bit value in its low bits.
// - Reset loads zero trim, leaving the fast oscillator at calibration.
// - A trim write starts slewing the fast oscillator; nothing stalls.
// - No flag or event reports that the slew has finished.
// - Trim never changes the slow internal oscillator rate.
// - Slow-clocked timers keep their timing when the trim changes.
// - Status bit shows external source versus internal oscillator as clock.
`timescale 1ns/1ps
module iots_top
    import iots_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Clock switch state
    input wire logic clock_from_internal,
    // Oscillator controls and status
    output logic [4:0] fast_internal_oscillator_trim,
    output logic startup_clock_status,
    output logic slow_internal_oscillator_tick
);
    typedef struct packed {
        logic [4:0] trim_value_reg;
        logic [4:0] applied_reg;
        logic [3:0] slew_cnt_reg;
        logic [7:0] rdata_reg;
        logic status_reg;
    } iots_state_t;

    iots_state_t st_reg;
    iots_state_t st_next;

    // One signed step of the applied trim toward the target
    function automatic logic [4:0] iots_step(input logic [4:0] cur, input logic [4:0] tgt);
        if ($signed(cur) < $signed(tgt))
        begin
            iots_step = cur + 5'h01;
        end
        else if ($signed(cur) > $signed(tgt))
        begin
            iots_step = cur - 5'h01;
        end
        else
        begin
            iots_step = cur;
        end
    endfunction : iots_step

    // Address match for one register of the port
    function automatic logic iots_hit(input logic [7:0] addr, input logic [7:0] offset);
        iots_hit = (addr == offset);
    endfunction : iots_hit

    ////////////////////////////////////////////////////////////////////////
    // Register port, slew and status
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata_reg = IOTS_RDATA_RESET;
        // Trim write keeps only the low five bits
        if (reg_wr && iots_hit(reg_addr, IOTS_TRIM_OFFSET))
        begin
            st_next.trim_value_reg = reg_wdata[IOTS_TRIM_WIDTH-1:0];
        end
        // Read data, upper trim bits and unmapped addresses read zero
        if (reg_rd)
        begin
            if (iots_hit(reg_addr, IOTS_TRIM_OFFSET))
            begin
                st_next.rdata_reg = {3'h0, st_reg.trim_value_reg};
            end
            else if (iots_hit(reg_addr, IOTS_OSC_CTRL_OFFSET))
            begin
                st_next.rdata_reg[IOTS_STATUS_BIT] = st_reg.status_reg;
            end
        end
        // Applied trim walks one step per slew period, never stalling the port
        if (st_reg.slew_cnt_reg == 4'h0)
        begin
            st_next.slew_cnt_reg = IOTS_SLEW_CYCLES;
            st_next.applied_reg = iots_step(st_reg.applied_reg, st_reg.trim_value_reg);
        end
        else
        begin
            st_next.slew_cnt_reg = st_reg.slew_cnt_reg - 4'h1;
        end
        // High while running from the external source
        st_next.status_reg = ~clock_from_internal;
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Slow timebase has no trim input
    iots_slow_timebase u_slow (
        .mclk(mclk),
        .rst(rst),
        .slow_tick(slow_internal_oscillator_tick)
    );

    // Outputs straight from the state register
    assign reg_rdata = st_reg.rdata_reg;
    assign fast_internal_oscillator_trim = st_reg.applied_reg;
    assign startup_clock_status = st_reg.status_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Register port strobes and slew phase as sequences
    sequence trim_wr_s;
        reg_wr && reg_addr == IOTS_TRIM_OFFSET;
    endsequence
    sequence trim_rd_s;
        reg_rd && reg_addr == IOTS_TRIM_OFFSET;
    endsequence
    sequence ctrl_rd_s;
        reg_rd && reg_addr == IOTS_OSC_CTRL_OFFSET;
    endsequence
    sequence other_rd_s;
        reg_rd && reg_addr != IOTS_TRIM_OFFSET && reg_addr != IOTS_OSC_CTRL_OFFSET;
    endsequence
    sequence slew_due_s;
        st_reg.slew_cnt_reg == 4'h0;
    endsequence
    sequence slew_wait_s;
        st_reg.slew_cnt_reg != 4'h0;
    endsequence

    // Trim register: write, hold, readback and reset
    trim_write_a: assert property (
        trim_wr_s ##1 trim_rd_s |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
        else $error("trim readback differs from written value");
    trim_take_a: assert property (
        trim_wr_s |=> st_reg.trim_value_reg == $past(reg_wdata[4:0]))
        else $error("trim write not taken");
    trim_hold_a: assert property (
        !(reg_wr && reg_addr == IOTS_TRIM_OFFSET) |=> $stable(st_reg.trim_value_reg))
        else $error("trim changed without a write");
    upper_bits_a: assert property (trim_rd_s |=> reg_rdata[7:5] == 3'h0)
        else $error("upper trim bits not zero");
    trim_reset_a: assert property (
        disable iff (1'b0) rst
        |=> st_reg.trim_value_reg == 5'h00 && fast_internal_oscillator_trim == 5'h00)
        else $error("trim not zero after reset");

    // Control read carries only the start-up status bit
    status_only_a: assert property (ctrl_rd_s |=> (reg_rdata & 8'hF7) == 8'h00)
        else $error("unexpected bits in control read");
    status_bit_a: assert property (
        ctrl_rd_s |=> reg_rdata[IOTS_STATUS_BIT] == $past(startup_clock_status))
        else $error("control read status bit wrong");
    status_track_a: assert property (
        ##1 startup_clock_status == !$past(clock_from_internal))
        else $error("start-up status does not follow clock source");

    // Read data stand one cycle; unmapped reads give zero
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without a read");
    unmapped_rd_a: assert property (other_rd_s |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // Slew counter runs free from reset and reloads at zero
    slew_count_a: assert property (
        slew_wait_s |=> st_reg.slew_cnt_reg == $past(st_reg.slew_cnt_reg) - 4'h1)
        else $error("slew counter skipped a count");
    slew_reload_a: assert property (
        slew_due_s |=> st_reg.slew_cnt_reg == IOTS_SLEW_CYCLES)
        else $error("slew counter did not reload");

    // Applied trim moves only on a slew step, one signed count at a time
    slew_idle_a: assert property (
        slew_wait_s |=> $stable(fast_internal_oscillator_trim))
        else $error("trim moved between slew steps");
    slew_step_a: assert property (
        fast_internal_oscillator_trim != $past(fast_internal_oscillator_trim)
        |-> ##1 $stable(fast_internal_oscillator_trim)[*8])
        else $error("trim slewed faster than one step per period");
    slew_toward_a: assert property (
        st_reg.slew_cnt_reg == 4'h0 && st_reg.applied_reg != st_reg.trim_value_reg
        |=> fast_internal_oscillator_trim != $past(fast_internal_oscillator_trim))
        else $error("trim slew did not move");
    slew_up_a: assert property (
        st_reg.slew_cnt_reg == 4'h0
        && $signed(st_reg.applied_reg) < $signed(st_reg.trim_value_reg)
        |=> fast_internal_oscillator_trim == $past(fast_internal_oscillator_trim) + 5'h01)
        else $error("trim slewed the wrong way upward");
    slew_down_a: assert property (
        st_reg.slew_cnt_reg == 4'h0
        && $signed(st_reg.applied_reg) > $signed(st_reg.trim_value_reg)
        |=> fast_internal_oscillator_trim == $past(fast_internal_oscillator_trim) - 5'h01)
        else $error("trim slewed the wrong way downward");
    slew_settle_a: assert property (
        st_reg.applied_reg == st_reg.trim_value_reg |=> $stable(fast_internal_oscillator_trim))
        else $error("settled trim moved");

    // Slow timebase keeps its period whatever the trim does
    slow_period_a: assert property (
        slow_internal_oscillator_tick |-> ##16 slow_internal_oscillator_tick)
        else $error("slow timebase period changed");
    slow_gap_a: assert property (
        slow_internal_oscillator_tick |=> (!slow_internal_oscillator_tick)[*8])
        else $error("slow timebase ticked early");
endmodule : iots_top

/* verification/tb_top.sv */
/*
 * Self-checking bench for the oscillator tuning block: register port,
 * trim slew, start-up status and the slow timebase.
 * Assumes iots_top with the byte register port and a 50 MHz clock.
 */
`timescale 1ns/1ps
module tb_top
    import iots_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic clock_from_internal = 1'b1;
    logic [4:0] trim;
    logic status;
    logic tick;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] d;
    int n;
    ////////////////////////////////////////////////////////////////////////
    // Clock and device
    always #10 mclk = ~mclk;
    iots_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clock_from_internal(clock_from_internal), .fast_internal_oscillator_trim(trim),
        .startup_clock_status(status), .slow_internal_oscillator_tick(tick));
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and verdict
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset_and_bits;
        rd(IOTS_TRIM_OFFSET);
        check("trim after reset", d, 8'h00);
        check("applied trim after reset", {3'h0, trim}, 8'h00);
        wr(IOTS_TRIM_OFFSET, 8'hFF);
        rd(IOTS_TRIM_OFFSET);
        check("trim upper bits", d, 8'h1F);
        wr(IOTS_TRIM_OFFSET, 8'hE0);
        rd(IOTS_TRIM_OFFSET);
        check("trim upper bits only", d, 8'h00);
        rd(8'h91);
        check("unmapped read", d, 8'h00);
        $display("test reset_and_bits done");
    endtask : test_reset_and_bits
    task automatic test_back_to_back;
        @(posedge mclk);
        reg_addr <= IOTS_TRIM_OFFSET;
        reg_wdata <= 8'hEA;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check("write then read", reg_rdata, 8'h0A);
        @(negedge mclk);
        check("read data gone", reg_rdata, 8'h00);
        $display("test back_to_back done");
    endtask : test_back_to_back
    task automatic test_slew;
        wr(IOTS_TRIM_OFFSET, 8'h03);
        rd(IOTS_TRIM_OFFSET);
        check("read during slew", d, 8'h03);
        repeat (80) @(negedge mclk);
        check("slewed to +3", {3'h0, trim}, 8'h03);
        wr(IOTS_TRIM_OFFSET, 8'h1D);
        repeat (120) @(negedge mclk);
        check("slewed to -3", {3'h0, trim}, 8'h1D);
        $display("test slew done");
    endtask : test_slew
    task automatic test_mid_reset;
        wr(IOTS_TRIM_OFFSET, 8'h07);
        repeat (80) @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(IOTS_TRIM_OFFSET);
        check("trim after mid reset", d, 8'h00);
        check("applied trim after mid reset", {3'h0, trim}, 8'h00);
        $display("test mid_reset done");
    endtask : test_mid_reset
    task automatic test_slow_tick;
        @(negedge mclk);
        while (tick !== 1'b1) @(negedge mclk);
        n = 0;
        fork
            wr(IOTS_TRIM_OFFSET, 8'h0F);
            begin
                @(negedge mclk);
                n = 1;
                while (tick !== 1'b1 && n < 40)
                begin
                    @(negedge mclk);
                    n++;
                end
            end
        join
        check("slow tick period", n[7:0], 8'h10);
        $display("test slow_tick done");
    endtask : test_slow_tick
    task automatic test_status;
        wr(IOTS_OSC_CTRL_OFFSET, 8'hFF);
        rd(IOTS_OSC_CTRL_OFFSET);
        check("status internal", d, 8'h00);
        wr(IOTS_TRIM_OFFSET, 8'h05);
        rd(IOTS_OSC_CTRL_OFFSET);
        check("no slew done flag", d, 8'h00);
        repeat (120) @(posedge mclk);
        rd(IOTS_OSC_CTRL_OFFSET);
        check("no slew done flag later", d, 8'h00);
        @(posedge mclk);
        clock_from_internal <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(IOTS_OSC_CTRL_OFFSET);
        check("status external", d, 8'h08);
        check("status pin", {7'h0, status}, 8'h01);
        $display("test status done");
    endtask : test_status
    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        test_reset_and_bits();
        test_back_to_back();
        test_slew();
        test_mid_reset();
        test_slow_tick();
        test_status();
        conclude();
    end
    initial
    begin
        #40000;
        fail_count++;
        conclude();
    end
endmodule : tb_top
